/* logic/bank_tracker.sv */
// One bank: open row state, auto precharge and recovery countdowns
`timescale 1ns/100ps
`default_nettype none
module bank_tracker (
  input  wire logic clk_sys_in,   // System clock
  input  wire logic srst_in,      // Sync reset
  input  wire logic tick_in,      // Internal edge enabled
  input  wire logic activate_in,  // Row opened
  input  wire logic precharge_in, // Precharge now
  input  wire logic auto_arm_in,  // Auto precharge armed
  input  wire logic auto_wr_in,   // Armed access is a write
  input  wire logic auto_fire_in, // Armed access ended
  output logic      open_out,     // Row active
  output logic      busy_out      // Write recovery, precharging or armed
);
  typedef struct packed {
    logic       open;
    logic       armed;
    logic       wr;
    logic [3:0] wr_cnt;
    logic [3:0] rp_cnt;
  } bank_state_t;
  bank_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (tick_in) begin
      if (s_q.rp_cnt != 4'h0) begin
        s_d.rp_cnt = s_q.rp_cnt - 4'h1;
      end
      if (s_q.wr_cnt != 4'h0) begin
        s_d.wr_cnt = s_q.wr_cnt - 4'h1;
        if (s_q.wr_cnt == 4'h1) begin
          s_d.open = 1'b0;
          s_d.rp_cnt = 4'(sdram_cmd_pkg::PRE_RECOVERY_CYC);
        end
      end
      if (activate_in) begin
        s_d.open = 1'b1;
      end
      if (auto_arm_in) begin
        s_d.armed = 1'b1;
        s_d.wr = auto_wr_in;
      end else if (auto_fire_in && s_q.armed) begin
        s_d.armed = 1'b0;
        if (s_q.wr) begin
          s_d.wr_cnt = 4'(sdram_cmd_pkg::WR_RECOVERY_CYC);
        end else begin
          s_d.open = 1'b0;
          s_d.rp_cnt = 4'(sdram_cmd_pkg::PRE_RECOVERY_CYC);
        end
      end
      if (precharge_in) begin
        s_d.open = 1'b0;
        s_d.armed = 1'b0;
        s_d.rp_cnt = 4'(sdram_cmd_pkg::PRE_RECOVERY_CYC);
      end
    end
    if (srst_in) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    s_q <= s_d;
  end

  assign open_out = s_q.open;
  assign busy_out = s_q.armed | (s_q.wr_cnt != 4'h0) | (s_q.rp_cnt != 4'h0);

  a_pre_closes: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    tick_in && precharge_in |=> !open_out && busy_out) else $error("Precharge left bank open");
endmodule
`default_nettype wire

/* logic/sdram_cmd_pkg.sv */
// Constants and types for the synchronous DRAM command and burst logic
package sdram_cmd_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WR_RECOVERY_NS = 15;
  localparam int WR_RECOVERY_CYC = (WR_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int PRE_RECOVERY_NS = 20;
  localparam int PRE_RECOVERY_CYC = (PRE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_BANKS = 4;
  localparam int COL_W = 8;
  localparam int ALL_BANKS_BIT = 10;
  localparam int BL_W = 3;
  // Burst length codes
  localparam logic [BL_W-1:0] BL_1 = 3'h0;
  localparam logic [BL_W-1:0] BL_2 = 3'h1;
  localparam logic [BL_W-1:0] BL_4 = 3'h2;
  localparam logic [BL_W-1:0] BL_8 = 3'h3;
  localparam logic [BL_W-1:0] BL_PAGE = 3'h7;
  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACTIVE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_STOP = 3'h6;
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_SUSPEND = 4'h2,
    ST_PD_PRE  = 4'h4,
    ST_PD_ACT  = 4'h8
  } mode_t;
  typedef enum logic [2:0] {
    BUR_IDLE  = 3'h1,
    BUR_WRITE = 3'h2,
    BUR_READ  = 3'h4
  } burst_t;
endpackage

/* logic/sdram_core.sv */
// Write burst, precharge, power-down and clock suspend logic of the DRAM
`timescale 1ns/100ps
`default_nettype none
module sdram_core #(
  parameter int COL_W = sdram_cmd_pkg::COL_W,
  parameter int DQ_W  = 16
) (
  input  wire logic                 clk_sys_in,       // System clock
  input  wire logic                 srst_in,          // Sync reset
  input  wire logic                 clk_gate_in,      // Clock gate pin
  input  wire logic                 cs_n_in,          // Chip select, low active
  input  wire logic                 ras_n_in,         // Row strobe, low active
  input  wire logic                 cas_n_in,         // Column strobe, low active
  input  wire logic                 we_n_in,          // Write enable, low active
  input  wire logic [1:0]           bank_in,          // Bank select high/low
  input  wire logic [11:0]          addr_in,          // Address, bit 10 all banks
  input  wire logic                 dqm_in,           // Byte mask
  input  wire logic [DQ_W-1:0]      dq_in,            // Data pin input
  input  wire logic [2:0]           burst_len_in,     // Programmed burst length
  input  wire logic                 write_burst_mode_bit_in, // Single write mode
  output logic                      wr_en_out,        // Array write strobe
  output logic [1:0]                wr_bank_out,      // Array write bank
  output logic [COL_W-1:0]          wr_col_out,       // Array write column
  output logic [DQ_W-1:0]           wr_data_out,      // Array write data
  output logic                      dq_oe_out,        // Data pin drive enable
  output logic [3:0]                bank_open_out,    // Rows open per bank
  output logic                      power_down_out,   // In power-down
  output logic                      buffers_on_out,   // Input/output buffers on
  output logic                      suspended_out,    // Clock suspended
  output logic                      write_active_out  // Write burst running
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Two flops before use; command and data are aligned by equal delay
  localparam int PIN_W = 1 + 4 + 2 + 12 + 1 + DQ_W;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pin_s1_q <= {1'b0, 4'hf, {(PIN_W-5){1'b0}}};
      pin_s2_q <= {1'b0, 4'hf, {(PIN_W-5){1'b0}}};
    end else begin
      pin_s1_q <= {clk_gate_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, bank_in, addr_in, dqm_in, dq_in};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic            gate;
  logic            cs_n;
  logic [2:0]      cmd;
  logic [1:0]      bank;
  logic [11:0]     addr;
  logic            dqm;
  logic [DQ_W-1:0] dq;
  assign {gate, cs_n, cmd, bank, addr, dqm, dq} = pin_s2_q;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    sdram_cmd_pkg::mode_t  mode;
    sdram_cmd_pkg::burst_t burst;
    logic                  gate_prev;
    logic [1:0]            bank;
    logic [COL_W-1:0]      col;
    logic [COL_W-1:0]      left;
    logic                  page;
    logic                  auto_pre;
    logic                  wr_en;
    logic [1:0]            wr_bank;
    logic [COL_W-1:0]      wr_col;
    logic [DQ_W-1:0]       wr_data;
  } core_state_t;
  core_state_t s_q, s_d;

  logic       tick;
  logic       is_nop;
  logic       cmd_wr;
  logic       cmd_rd;
  logic       cmd_pre;
  logic       cmd_stop;
  logic       cmd_act;
  logic [3:0] open_v;
  logic [3:0] busy_v;
  logic [3:0] act_v;
  logic [3:0] pre_v;
  logic [3:0] arm_v;
  logic [3:0] fire_v;
  logic       any_open;
  logic       in_access;
  logic [COL_W-1:0] burst_cnt;

  // Internal edge only when running and the previous gate sample was high
  assign tick     = (s_q.mode == sdram_cmd_pkg::ST_RUN) && s_q.gate_prev;
  assign is_nop   = cs_n || (cmd == sdram_cmd_pkg::CMD_NOP);
  assign cmd_wr   = tick && !cs_n && (cmd == sdram_cmd_pkg::CMD_WRITE);
  assign cmd_rd   = tick && !cs_n && (cmd == sdram_cmd_pkg::CMD_READ);
  assign cmd_pre  = tick && !cs_n && (cmd == sdram_cmd_pkg::CMD_PRECHARGE);
  assign cmd_stop = tick && !cs_n && (cmd == sdram_cmd_pkg::CMD_STOP);
  assign cmd_act  = tick && !cs_n && (cmd == sdram_cmd_pkg::CMD_ACTIVE);
  assign any_open  = |open_v;
  assign in_access = s_q.burst != sdram_cmd_pkg::BUR_IDLE;

  always_comb begin
    case (burst_len_in)
      sdram_cmd_pkg::BL_2:    burst_cnt = COL_W'(2);
      sdram_cmd_pkg::BL_4:    burst_cnt = COL_W'(4);
      sdram_cmd_pkg::BL_8:    burst_cnt = COL_W'(8);
      default:                burst_cnt = COL_W'(1);
    endcase
  end

  // ==========================================================
  // Bank trackers
  // ==========================================================
  always_comb begin
    act_v  = '0;
    pre_v  = '0;
    arm_v  = '0;
    fire_v = '0;
    if (cmd_act) begin
      act_v[bank] = 1'b1;
    end
    if (cmd_pre) begin
      pre_v = addr[sdram_cmd_pkg::ALL_BANKS_BIT] ? 4'hf : (4'h1 << bank);
    end
    if ((cmd_wr || cmd_rd) && addr[sdram_cmd_pkg::ALL_BANKS_BIT]) begin
      arm_v[bank] = 1'b1;
    end
    // New access to another bank, or natural end, releases the armed bank
    if (s_q.auto_pre && in_access) begin
      if ((cmd_wr || cmd_rd) && (bank != s_q.bank)) begin
        fire_v[s_q.bank] = 1'b1;
      end else if (tick && !s_q.page && s_q.left == COL_W'(1)) begin
        fire_v[s_q.bank] = 1'b1;
      end
    end
    // Single-column write with auto precharge releases its bank on the next edge
    if (s_q.auto_pre && !in_access && tick) begin
      fire_v[s_q.bank] = 1'b1;
    end
  end

  for (genvar b = 0; b < sdram_cmd_pkg::NUM_BANKS; b++) begin : g_bank
    bank_tracker u_bank (
      .clk_sys_in   (clk_sys_in),
      .srst_in      (srst_in),
      .tick_in      (tick),
      .activate_in  (act_v[b]),
      .precharge_in (pre_v[b]),
      .auto_arm_in  (arm_v[b]),
      .auto_wr_in   (cmd_wr),
      .auto_fire_in (fire_v[b]),
      .open_out     (open_v[b]),
      .busy_out     (busy_v[b])
    );
  end

  // ==========================================================
  // Mode and burst engine
  // ==========================================================
  always_comb begin
    s_d = s_q;
    s_d.gate_prev = gate;
    s_d.wr_en = 1'b0;
    case (s_q.mode)
      sdram_cmd_pkg::ST_RUN: begin
        if (!gate && in_access) begin
          s_d.mode = sdram_cmd_pkg::ST_SUSPEND;
        end else if (!gate && is_nop && tick) begin
          // A bank still recovering is not idle either
          s_d.mode = (any_open || (|busy_v)) ? sdram_cmd_pkg::ST_PD_ACT : sdram_cmd_pkg::ST_PD_PRE;
        end
      end
      sdram_cmd_pkg::ST_SUSPEND: begin
        if (gate) begin
          s_d.mode = sdram_cmd_pkg::ST_RUN;
        end
      end
      sdram_cmd_pkg::ST_PD_PRE, sdram_cmd_pkg::ST_PD_ACT: begin
        if (gate && is_nop) begin
          s_d.mode = sdram_cmd_pkg::ST_RUN;
        end
      end
      default: begin
        s_d.mode = sdram_cmd_pkg::ST_RUN;
      end
    endcase

    // Burst engine advances only on internal edges; counters hold otherwise
    if (tick) begin
      // Arm of a single-column write is spent once it has fired
      if (!in_access) begin
        s_d.auto_pre = 1'b0;
      end
      if (s_q.burst == sdram_cmd_pkg::BUR_WRITE) begin
        if (!dqm && !cmd_stop) begin
          s_d.wr_en = !(cmd_rd || cmd_wr);
          s_d.wr_bank = s_q.bank;
          s_d.wr_col = s_q.col;
          s_d.wr_data = dq;
        end
      end
      if (in_access) begin
        s_d.col = s_q.col + COL_W'(1);
        if (!s_q.page && s_q.left == COL_W'(1)) begin
          s_d.burst = sdram_cmd_pkg::BUR_IDLE;
          s_d.auto_pre = 1'b0;
        end else begin
          s_d.left = s_q.left - COL_W'(1);
        end
      end
      if (cmd_stop || cmd_pre) begin
        s_d.burst = sdram_cmd_pkg::BUR_IDLE;
        s_d.auto_pre = 1'b0;
      end
      if (cmd_wr) begin
        // First datum rides with the command edge
        s_d.wr_en = !dqm;
        s_d.wr_bank = bank;
        s_d.wr_col = addr[COL_W-1:0];
        s_d.wr_data = dq;
        s_d.bank = bank;
        s_d.col = addr[COL_W-1:0] + COL_W'(1);
        s_d.auto_pre = addr[sdram_cmd_pkg::ALL_BANKS_BIT];
        s_d.page = !write_burst_mode_bit_in && (burst_len_in == sdram_cmd_pkg::BL_PAGE);
        s_d.left = burst_cnt - COL_W'(1);
        // Single write mode or burst of one finishes here
        if (write_burst_mode_bit_in || (!s_d.page && burst_cnt == COL_W'(1))) begin
          s_d.burst = sdram_cmd_pkg::BUR_IDLE;
        end else begin
          s_d.burst = sdram_cmd_pkg::BUR_WRITE;
        end
      end
      if (cmd_rd) begin
        s_d.bank = bank;
        s_d.col = addr[COL_W-1:0] + COL_W'(1);
        s_d.auto_pre = addr[sdram_cmd_pkg::ALL_BANKS_BIT];
        s_d.page = burst_len_in == sdram_cmd_pkg::BL_PAGE;
        s_d.left = burst_cnt;
        s_d.burst = sdram_cmd_pkg::BUR_READ;
      end
    end
    if (srst_in) begin
      s_d = '0;
      s_d.mode = sdram_cmd_pkg::ST_RUN;
      s_d.burst = sdram_cmd_pkg::BUR_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    s_q <= s_d;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign wr_en_out        = s_q.wr_en;
  assign wr_bank_out      = s_q.wr_bank;
  assign wr_col_out       = s_q.wr_col;
  assign wr_data_out      = s_q.wr_data;
  // Read data path lies outside this block; pins never driven by writes
  assign dq_oe_out        = 1'b0;
  assign bank_open_out    = open_v;
  assign power_down_out   = (s_q.mode == sdram_cmd_pkg::ST_PD_PRE) || (s_q.mode == sdram_cmd_pkg::ST_PD_ACT);
  assign buffers_on_out   = !power_down_out;
  assign suspended_out    = s_q.mode == sdram_cmd_pkg::ST_SUSPEND;
  assign write_active_out = s_q.burst == sdram_cmd_pkg::BUR_WRITE;

  // ==========================================================
  // Checks
  // ==========================================================
  a_write_first: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cmd_wr && !dqm |=> wr_en_out && wr_col_out == $past(addr[COL_W-1:0])) else $error("First datum lost");
  a_single_write: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cmd_wr && write_burst_mode_bit_in |=> !write_active_out) else $error("Single write mode ran burst");
  a_read_stops: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cmd_rd |=> !wr_en_out ##1 (!wr_en_out || $past(cmd_wr))) else $error("Write after read");
  a_stop_drop: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cmd_stop |=> !wr_en_out && !write_active_out) else $error("Burst stop data written");
  a_suspend_hold: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    suspended_out |=> !wr_en_out && $stable(s_q.col)) else $error("Suspended edge advanced");
  a_suspend_exit: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    suspended_out && gate |=> !suspended_out) else $error("Suspend not left");
  a_pd_entry: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    tick && !gate && is_nop && !in_access |=> power_down_out) else $error("Power-down not entered");
  a_pd_buffers: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    power_down_out |-> !buffers_on_out && !wr_en_out) else $error("Buffers on in power-down");
  a_pd_exit: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    power_down_out && gate && is_nop |=> !power_down_out) else $error("Power-down not left");
  a_pre_all: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cmd_pre && addr[sdram_cmd_pkg::ALL_BANKS_BIT] |=> bank_open_out == 4'h0) else $error("Precharge all missed");
  a_suspend_entry: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    tick && !gate && in_access |=> suspended_out) else $error("Suspend not entered");
  a_write_trunc: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cmd_wr && write_active_out && !dqm |=> wr_bank_out == $past(bank) && wr_data_out == $past(dq))
    else $error("New write data lost");
  a_page_run: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    tick && write_active_out && s_q.page && !(cmd_stop || cmd_pre || cmd_rd || cmd_wr)
    |=> write_active_out) else $error("Full-page burst ended");
  c_write_burst: cover property (@(posedge clk_sys_in) cmd_wr ##1 write_active_out [*3]);
  c_suspend: cover property (@(posedge clk_sys_in) write_active_out && suspended_out);
  c_power_down: cover property (@(posedge clk_sys_in) power_down_out ##1 !power_down_out);
  c_auto_fire: cover property (@(posedge clk_sys_in) |fire_v);
endmodule
`default_nettype wire

/* testbench/dram_ctrl_model.sv */
// Host-side controller model driving the DRAM command, mask and data pins
`timescale 1ns/100ps
`default_nettype none
module dram_ctrl_model (
  input  wire logic  clk_sys_in, // System clock
  output logic       gate_out,   // Clock gate
  output logic       cs_n_out,   // Chip select, low active
  output logic [2:0] cmd_out,    // {ras_n, cas_n, we_n}
  output logic [1:0] bank_out,   // Bank select
  output logic [11:0] addr_out,  // Address
  output logic       dqm_out,    // Byte mask
  output logic [15:0] dq_out     // Write data
);
  logic sel_n;
  initial begin
    gate_out = 1'h1;
    cs_n_out = 1'h0;
    sel_n    = 1'h0;
    cmd_out  = sdram_cmd_pkg::CMD_NOP;
    bank_out = 2'h0;
    addr_out = 12'h0;
    dqm_out  = 1'h0;
    dq_out   = 16'h5a5a;
  end
  // ==========================================
  // Pin driving, one command per edge
  task automatic drive(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic m, input logic [15:0] d, input logic g);
    @(posedge clk_sys_in);
    cmd_out  <= c;
    bank_out <= b;
    addr_out <= a;
    dqm_out  <= m;
    dq_out   <= d;
    gate_out <= g;
    cs_n_out <= sel_n;
  endtask
  // Released data lines toggle so a stale word never looks valid
  task automatic idle(input int n);
    repeat (n) drive(sdram_cmd_pkg::CMD_NOP, 2'h0, 12'h0, 1'h0, ~dq_out, 1'h1);
  endtask
  task automatic open_row(input logic [1:0] b);
    drive(sdram_cmd_pkg::CMD_ACTIVE, b, 12'h0, 1'h0, ~dq_out, 1'h1);
    idle(1);
  endtask
  // Masked recovery edge, then masked precharge, then recovery wait
  task automatic close_row(input logic [1:0] b, input logic all);
    repeat (sdram_cmd_pkg::WR_RECOVERY_CYC - 1) drive(sdram_cmd_pkg::CMD_NOP, b, 12'h0, 1'h1, ~dq_out, 1'h1);
    drive(sdram_cmd_pkg::CMD_PRECHARGE, b, {1'h0, all, 10'h0}, 1'h1, ~dq_out, 1'h1);
    idle(sdram_cmd_pkg::PRE_RECOVERY_CYC);
  endtask
  // Stays far below the refresh period
  task automatic sleep(input int n);
    repeat (n) drive(sdram_cmd_pkg::CMD_NOP, 2'h0, 12'h0, 1'h0, ~dq_out, 1'h0);
  endtask
  // Deselected edges carry a write pattern that must never land
  task automatic deselect(input int n, input logic g);
    sel_n = 1'h1;
    repeat (n) drive(sdram_cmd_pkg::CMD_WRITE, 2'h0, 12'h0, 1'h0, ~dq_out, g);
    sel_n = 1'h0;
  endtask
endmodule
`default_nettype wire

/* testbench/test_sdram_write_precharge_power_logic.sv */
// Self-checking bench for the write, precharge, power-down and suspend logic
`timescale 1ns/100ps
`default_nettype none
module test_sdram_write_precharge_power_logic;
  logic clk_sys_in, srst_in, gate, cs_n, dqm, mode_bit, wr_en, dq_oe, pd, buf_on, sus, wr_act, sus_seen;
  logic [2:0] cmd, burst_len;
  logic [1:0] bank, wr_bank;
  logic [11:0] addr;
  logic [15:0] dq, wr_data;
  logic [7:0] wr_col;
  logic [3:0] bank_open;
  logic [25:0] got_q[$];
  logic [25:0] exp_q[$];
  int fails = 0;
  int n_checks = 0;
  sdram_core DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .clk_gate_in(gate), .cs_n_in(cs_n),
    .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .bank_in(bank), .addr_in(addr),
    .dqm_in(dqm), .dq_in(dq), .burst_len_in(burst_len), .write_burst_mode_bit_in(mode_bit),
    .wr_en_out(wr_en), .wr_bank_out(wr_bank), .wr_col_out(wr_col), .wr_data_out(wr_data),
    .dq_oe_out(dq_oe), .bank_open_out(bank_open), .power_down_out(pd), .buffers_on_out(buf_on),
    .suspended_out(sus), .write_active_out(wr_act));
  dram_ctrl_model ctl (.clk_sys_in(clk_sys_in), .gate_out(gate), .cmd_out(cmd), .bank_out(bank),
    .cs_n_out(cs_n), .addr_out(addr), .dqm_out(dqm), .dq_out(dq));
  initial begin
    clk_sys_in = 1'h0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // ==========================================
  // Array write monitor
  always @(posedge clk_sys_in) begin
    if (wr_en === 1'h1) got_q.push_back({wr_bank, wr_col, wr_data});
    if (sus === 1'h1) sus_seen <= 1'h1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cfg(input logic [2:0] bl, input logic m);
    @(posedge clk_sys_in);
    burst_len <= bl;
    mode_bit  <= m;
  endtask
  task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic [15:0] d);
    exp_q.push_back({b, c, d});
  endtask
  task automatic cmd_wr(input logic [2:0] c, input logic [1:0] b, input logic [7:0] col, input logic [15:0] d);
    ctl.drive(c, b, {4'h0, col}, 1'h0, d, 1'h1);
  endtask
  // Bounded wait for the burst to drain, then compare all array writes
  task automatic finish_test(input string name);
    int n;
    n = 0;
    ctl.idle(4);
    while (wr_act !== 1'h0 && n < 40) begin
      ctl.idle(1);
      n++;
    end
    if (n == 40) begin
      fails++;
      $display("unexpected at %0t: burst never drained", $time);
      tally_and_finish();
    end
    ctl.idle(2);
    check(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) check(32'(got_q[i]), 32'(exp_q[i]));
    got_q.delete();
    exp_q.delete();
    $display("test %s done", name);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_burst();
    cfg(sdram_cmd_pkg::BL_4, 1'h0);
    ctl.open_row(2'h1);
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h1, 8'h05, 16'ha000);
    for (int i = 1; i < 6; i++) cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'ha000 + 16'(i));
    for (int i = 0; i < 4; i++) wr(2'h1, 8'h05 + 8'(i), 16'ha000 + 16'(i));
    finish_test("burst");
    check(32'(dq_oe), 32'h0);
  endtask
  task automatic t_page_stop();
    cfg(sdram_cmd_pkg::BL_PAGE, 1'h0);
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h1, 8'hfe, 16'hb000);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'hb001);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'hb002);
    cmd_wr(sdram_cmd_pkg::CMD_STOP, 2'h0, 8'h00, 16'hb003);
    for (int i = 0; i < 3; i++) wr(2'h1, 8'hfe + 8'(i), 16'hb000 + 16'(i));
    finish_test("page_stop");
  endtask
  task automatic t_truncate();
    cfg(sdram_cmd_pkg::BL_4, 1'h0);
    ctl.open_row(2'h2);
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h1, 8'h10, 16'hc000);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'hc001);
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h2, 8'h20, 16'hc002);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'hc003);
    cmd_wr(sdram_cmd_pkg::CMD_READ, 2'h2, 8'h20, 16'hc004);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'hc005);
    wr(2'h1, 8'h10, 16'hc000);
    wr(2'h1, 8'h11, 16'hc001);
    wr(2'h2, 8'h20, 16'hc002);
    wr(2'h2, 8'h21, 16'hc003);
    finish_test("truncate");
  endtask
  task automatic t_mask_close();
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h1, 8'h30, 16'hd000);
    ctl.drive(sdram_cmd_pkg::CMD_NOP, 2'h0, 12'h0, 1'h1, 16'hd001, 1'h1);
    ctl.close_row(2'h1, 1'h0);
    wr(2'h1, 8'h30, 16'hd000);
    finish_test("mask_close");
    check(32'(bank_open), 32'h4);
    ctl.open_row(2'h0);
    ctl.open_row(2'h3);
    ctl.close_row(2'h3, 1'h0);
    ctl.idle(4);
    check(32'(bank_open), 32'h5);
    ctl.close_row(2'h0, 1'h1);
    ctl.idle(4);
    check(32'(bank_open), 32'h0);
    $display("test precharge done");
  endtask
  task automatic t_single();
    cfg(sdram_cmd_pkg::BL_8, 1'h1);
    ctl.open_row(2'h0);
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h0, 8'h40, 16'he000);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'he001);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'he002);
    wr(2'h0, 8'h40, 16'he000);
    finish_test("single");
    cfg(sdram_cmd_pkg::BL_4, 1'h0);
  endtask
  task automatic t_suspend();
    sus_seen = 1'h0;
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h0, 8'h50, 16'hf000);
    ctl.drive(sdram_cmd_pkg::CMD_NOP, 2'h0, 12'h0, 1'h0, 16'hf001, 1'h0);
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h0, 8'h70, 16'hf002);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'hf003);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'hf004);
    wr(2'h0, 8'h50, 16'hf000);
    wr(2'h0, 8'h51, 16'hf001);
    wr(2'h0, 8'h52, 16'hf003);
    wr(2'h0, 8'h53, 16'hf004);
    finish_test("suspend");
    check(32'(sus_seen), 32'h1);
  endtask
  task automatic t_auto();
    ctl.open_row(2'h3);
    ctl.drive(sdram_cmd_pkg::CMD_WRITE, 2'h0, 12'h480, 1'h0, 16'h7000, 1'h1);
    cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'h7001);
    cmd_wr(sdram_cmd_pkg::CMD_WRITE, 2'h3, 8'h90, 16'h7002);
    for (int i = 3; i < 6; i++) cmd_wr(sdram_cmd_pkg::CMD_NOP, 2'h0, 8'h00, 16'h7000 + 16'(i));
    wr(2'h0, 8'h80, 16'h7000);
    wr(2'h0, 8'h81, 16'h7001);
    for (int i = 0; i < 4; i++) wr(2'h3, 8'h90 + 8'(i), 16'h7002 + 16'(i));
    finish_test("auto_precharge");
    check(32'(bank_open), 32'h8);
  endtask
  task automatic t_power();
    ctl.deselect(2, 1'h1);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) ctl.sleep(3);
      else ctl.deselect(3, 1'h0);
      ctl.drive(sdram_cmd_pkg::CMD_WRITE, 2'h0, 12'h060, 1'h0, 16'h1234, 1'h0);
      ctl.sleep(3);
      check(32'(pd), 32'h1);
      check(32'(buf_on), 32'h0);
      if (k == 0) ctl.drive(sdram_cmd_pkg::CMD_NOP, 2'h0, 12'h0, 1'h0, 16'h0, 1'h1);
      else ctl.deselect(1, 1'h1);
      ctl.idle(4);
      check(32'(pd), 32'h0);
      check(32'(buf_on), 32'h1);
      finish_test("power_down");
      ctl.close_row(2'h0, 1'h1);
    end
  endtask
  initial begin
    srst_in   = 1'h1;
    burst_len = sdram_cmd_pkg::BL_4;
    mode_bit  = 1'h0;
    sus_seen  = 1'h0;
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'h0;
    ctl.idle(2);
    t_burst();
    t_page_stop();
    t_truncate();
    t_mask_close();
    t_single();
    t_suspend();
    t_auto();
    t_power();
    tally_and_finish();
  end
endmodule
`default_nettype wire
